// ===== rtl/bcg_gate_ctrl.v
`timescale 1ns/1ps
`include "bcg_regs.vh"

// Notes on behaviour
// - Cycle select sampled at end of status state enables commands and the command-state control outputs; address strobe ignores it.
// - Unselected cycle keeps commands off and direction high; data enable off except in a high-speed write's status state.
// - Unselected cycle ignores delay, gate and ready until a new cycle starts.
// - Sampled cycle select is held internally for the rest of the cycle.
// - High-speed writes raise data enable in status state, selected or not.
// - Strap high makes the shared pin an active-low arbiter grant for tri-state.
// - Grant withdrawn floats commands and drops data enable at once.
// - Grant asserted: data enable follows at once, commands three edges later.
// - Strap low: gate falling forces commands and data enable inactive at once.
// - Gate rising restores commands and data enable to the cycle's state.
// - Selected cycle with gate low still needs ready to end.
// - Commands wait for command delay low; other outputs ignore it.
// - Command delay sampled at end of status state, then every edge.
// - Delay released: high-speed command at once, shared mode not before normal timing.
// - Ready before delay release: no command, data enable and direction end normally.
// - Shared-bus operation needs selection and grant; one controller per cycle.
// - Ready high at end of command state repeats it; low ends the cycle.
// - Shared mode delays read command one clock and write command two.
// - Address strobe in status state, except halt, independent of control inputs.
module bcg_gate_ctrl #(
   parameter CNT_W = 16
) (
   // Clock and reset.
   input wire CLK,
   input wire RST_B,
   // APB slave.
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   // Processor status and decoder inputs.
   input wire CYCLE_STATUS_HI_B,
   input wire CYCLE_STATUS_LO_B,
   input wire MEM_IO,
   input wire CYCLE_SELECT_LATCHED,
   // Control inputs.
   input wire SHARED_GATE_PIN,
   input wire COMMAND_DELAY_REQ,
   input wire READY_B,
   input wire BUS_TIMING_STRAP,
   // Command outputs, active low, three-state via enable.
   output wire [4:0] CMD_B,
   output wire CMD_OE,
   // Control outputs.
   output wire ADDR_LATCH_STROBE,
   output wire CASCADE_ENABLE_OUT,
   output wire DATA_ENABLE_OUT,
   output wire DATA_DIRECTION_OUT
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_STATUS = 2'b01;
   localparam [1:0] ST_COMMAND = 2'b10;

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   wire [7:0] pin_s;
   bcg_sync #(
      .W(8),
      .RST_VAL(`BCG_PIN_RST)
   ) u_sync (
      .clk(CLK),
      .rst_b(RST_B),
      .d({BUS_TIMING_STRAP, READY_B, COMMAND_DELAY_REQ, SHARED_GATE_PIN,
          CYCLE_SELECT_LATCHED, MEM_IO, CYCLE_STATUS_HI_B, CYCLE_STATUS_LO_B}),
      .q(pin_s)
   );

   wire s_lo_b = pin_s[0];
   wire s_hi_b = pin_s[1];
   wire s_mio = pin_s[2];
   wire sel_s = pin_s[3];
   wire gate_s = pin_s[4];
   wire command_delay_req_s = pin_s[5];
   wire ready_b_s = pin_s[6];
   wire strap_s = pin_s[7];

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg ctrl_en_ff;
   reg strap_ff;
   reg [1:0] strap_age_ff;
   reg sel_ff;
   reg dly_ok_ff;
   reg [1:0] tc_cnt_ff;
   reg [1:0] gcnt_ff;
   reg [4:0] kind_ff;
   reg is_rd_ff;
   reg is_wr_ff;
   reg cmd_ff;
   reg cmd_seen_ff;
   reg den_ff;
   reg dtr_ff;
   reg ale_ff;
   reg mce_ff;
   reg [CNT_W-1:0] cyc_cnt_ff;
   reg [CNT_W-1:0] nocmd_cnt_ff;
   reg [31:0] prdata_ff;

   // ----------------------------------------
   // Cycle decode from the status lines
   // ----------------------------------------
   wire status_act = ~(s_hi_b & s_lo_b);
   wire dec_halt = s_mio & ~s_hi_b & ~s_lo_b;
   wire dec_wr = s_hi_b & ~s_lo_b;
   wire dec_rd = status_act & ~dec_wr & ~dec_halt;
   reg [4:0] dec_kind;

   // One-hot command choice for the cycle type being started.
   always @* begin
      dec_kind = 5'h00;
      if (!s_mio && !s_hi_b && !s_lo_b) begin
         dec_kind[`BCG_CMD_INTA] = 1'b1;
      end else if (!s_mio && !s_hi_b) begin
         dec_kind[`BCG_CMD_IORD] = 1'b1;
      end else if (!s_mio && !s_lo_b) begin
         dec_kind[`BCG_CMD_IOWR] = 1'b1;
      end else if (s_mio && s_lo_b && !s_hi_b) begin
         dec_kind[`BCG_CMD_MRD] = 1'b1;
      end else if (s_mio && s_hi_b && !s_lo_b) begin
         dec_kind[`BCG_CMD_MWR] = 1'b1;
      end
   end

   // ----------------------------------------
   // Bus state sequencing
   // ----------------------------------------
   wire start_ok = status_act & ctrl_en_ff;
   wire cyc_end = (state_ff == ST_COMMAND) & ~ready_b_s;

   // Halt and unselected cycles drop to idle, so every control input
   // is ignored until the status lines open the next cycle.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start_ok) begin
               nxt_state = ST_STATUS;
            end
         end
         ST_STATUS: begin
            if (!is_rd_ff && !is_wr_ff) begin
               nxt_state = ST_IDLE;
            end else if (!sel_s) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_state = ST_COMMAND;
            end
         end
         ST_COMMAND: begin
            // Ready is still required even when the gate holds commands off.
            if (cyc_end) begin
               nxt_state = start_ok ? ST_STATUS : ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   wire enter_ts = (nxt_state == ST_STATUS);
   wire next_tc = (nxt_state == ST_COMMAND);
   wire next_rd = enter_ts ? dec_rd : is_rd_ff;
   wire next_wr = enter_ts ? dec_wr : is_wr_ff;
   wire next_inta = enter_ts ? dec_kind[`BCG_CMD_INTA] : kind_ff[`BCG_CMD_INTA];
   wire [1:0] nxt_tc_cnt = (state_ff == ST_COMMAND && tc_cnt_ff != 2'h3) ?
                           tc_cnt_ff + 2'h1 : ((state_ff == ST_COMMAND) ? tc_cnt_ff : 2'h0);
   wire [1:0] cmd_need = !strap_ff ? 2'h0 :
                         (is_wr_ff ? `BCG_WR_DELAY : `BCG_RD_DELAY);
   wire dly_clear = (~command_delay_req_s) | dly_ok_ff;
   wire nxt_cmd = next_tc & dly_clear & (nxt_tc_cnt >= cmd_need);
   wire den_wr_tc = ~strap_ff | (nxt_tc_cnt >= `BCG_WR_DEN_DELAY);
   // High-speed writes open the data path in the status state already.
   wire strap_ctl_pending = strap_ff;
   wire nxt_den = (enter_ts & next_wr & ~strap_ctl_pending) |
                  (next_tc & (next_rd | (next_wr & den_wr_tc)));

   // ----------------------------------------
   // Cycle registers
   // ----------------------------------------
   // The select level is caught once and held, so the decoder may change.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_ff <= ST_IDLE;
         kind_ff <= 5'h00;
         is_rd_ff <= 1'b0;
         is_wr_ff <= 1'b0;
         sel_ff <= 1'b0;
         dly_ok_ff <= 1'b0;
         tc_cnt_ff <= 2'h0;
         cmd_ff <= 1'b0;
         cmd_seen_ff <= 1'b0;
         den_ff <= 1'b0;
         dtr_ff <= 1'b1;
         ale_ff <= 1'b0;
         mce_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         tc_cnt_ff <= nxt_tc_cnt;
         if (enter_ts) begin
            kind_ff <= dec_kind;
            is_rd_ff <= dec_rd;
            is_wr_ff <= dec_wr;
            sel_ff <= 1'b0;
            dly_ok_ff <= 1'b0;
            cmd_seen_ff <= 1'b0;
         end else begin
            if (state_ff == ST_STATUS) begin
               sel_ff <= sel_s;
            end
            if (next_tc && !command_delay_req_s) begin
               dly_ok_ff <= 1'b1;
            end
            if (nxt_cmd) begin
               cmd_seen_ff <= 1'b1;
            end
         end
         cmd_ff <= nxt_cmd;
         den_ff <= nxt_den;
         dtr_ff <= ~(next_tc & next_rd);
         ale_ff <= enter_ts & (next_rd | next_wr);
         mce_ff <= next_inta & (enter_ts | (next_tc && state_ff == ST_STATUS));
      end
   end

   // ----------------------------------------
   // Strap capture and grant timing
   // ----------------------------------------
   // The strap is followed until the synchroniser has flushed its reset
   // image, then frozen; later changes of the pin are not followed.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         strap_ff <= 1'b0;
         strap_age_ff <= 2'h0;
         gcnt_ff <= 2'h0;
      end else begin
         if (strap_age_ff != 2'h3) begin
            strap_ff <= strap_s;
            strap_age_ff <= strap_age_ff + 2'h1;
         end
         if (gate_s) begin
            gcnt_ff <= 2'h0;
         end else if (gcnt_ff != `BCG_GRANT_EDGES) begin
            gcnt_ff <= gcnt_ff + 2'h1;
         end
      end
   end

   // ----------------------------------------
   // Output gating by the shared pin
   // ----------------------------------------
   // Gating is combinational on the synchronised pin, so it acts without
   // waiting for the cycle logic, at the cost of the two-stage latency.
   wire grant_ok = ~gate_s & (gcnt_ff == `BCG_GRANT_EDGES);
   wire cmd_live = strap_ff ? (cmd_ff & sel_ff) : (cmd_ff & sel_ff & gate_s);
   wire den_live = strap_ff ? (den_ff & ~gate_s) : (den_ff & gate_s);
   wire den_sel = den_ff & (sel_ff | state_ff != ST_COMMAND);

   assign CMD_B = ~(kind_ff & {5{cmd_live}});
   assign CMD_OE = strap_ff ? grant_ok : 1'b1;
   assign DATA_ENABLE_OUT = den_live & den_sel;
   assign DATA_DIRECTION_OUT = dtr_ff;
   assign ADDR_LATCH_STROBE = ale_ff;
   assign CASCADE_ENABLE_OUT = mce_ff;

   // ----------------------------------------
   // APB register file
   // ----------------------------------------
   wire apb_setup = PSEL & ~PENABLE;
   wire apb_wr = PSEL & PENABLE & PWRITE;
   wire hit_ctrl = (PADDR == `BCG_OFS_CTRL);
   wire hit_status = (PADDR == `BCG_OFS_STATUS);
   wire hit_cyc = (PADDR == `BCG_OFS_CYC_CNT);
   wire hit_nocmd = (PADDR == `BCG_OFS_NOCMD_CNT);
   wire mapped = hit_ctrl | hit_status | hit_cyc | hit_nocmd;
   wire cnt_clr = apb_wr & hit_ctrl & PWDATA[`BCG_CTRL_CLR_BIT];
   wire nocmd_evt = cyc_end & ~cmd_seen_ff;
   reg [31:0] rd_mux;

   // Read data is picked from the address during setup.
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[`BCG_CTRL_EN_BIT] = ctrl_en_ff;
      end else if (hit_status) begin
         rd_mux[`BCG_ST_STATE_LSB+1:`BCG_ST_STATE_LSB] = state_ff;
         rd_mux[`BCG_ST_CMD_BIT] = cmd_live;
         rd_mux[`BCG_ST_DLY_OK_BIT] = dly_ok_ff;
         rd_mux[`BCG_ST_SEL_BIT] = sel_ff;
         rd_mux[`BCG_ST_GATE_BIT] = gate_s;
         rd_mux[`BCG_ST_GRANT_BIT] = grant_ok;
         rd_mux[`BCG_ST_STRAP_BIT] = strap_ff;
      end else if (hit_cyc) begin
         rd_mux[CNT_W-1:0] = cyc_cnt_ff;
      end else if (hit_nocmd) begin
         rd_mux[CNT_W-1:0] = nocmd_cnt_ff;
      end
   end

   // Counters favour a same-cycle event over a software clear.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_en_ff <= `BCG_CTRL_RST;
         cyc_cnt_ff <= {CNT_W{1'b0}};
         nocmd_cnt_ff <= {CNT_W{1'b0}};
         prdata_ff <= 32'h0000_0000;
      end else begin
         if (apb_wr && hit_ctrl) begin
            ctrl_en_ff <= PWDATA[`BCG_CTRL_EN_BIT];
         end
         if (apb_setup) begin
            prdata_ff <= rd_mux;
         end
         if (cnt_clr) begin
            cyc_cnt_ff <= {{(CNT_W-1){1'b0}}, cyc_end};
            nocmd_cnt_ff <= {{(CNT_W-1){1'b0}}, nocmd_evt};
         end else begin
            if (cyc_end) begin
               cyc_cnt_ff <= cyc_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            if (nocmd_evt) begin
               nocmd_cnt_ff <= nocmd_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // Zero-wait slave; an unmapped address answers with an error.
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;
   assign PRDATA = prdata_ff;

endmodule

// ===== include/bcg_regs.vh
`ifndef BCG_REGS_VH
`define BCG_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BCG_OFS_CTRL 12'h000
`define BCG_OFS_STATUS 12'h004
`define BCG_OFS_CYC_CNT 12'h008
`define BCG_OFS_NOCMD_CNT 12'h00C

// ----------------------------------------
// Control register fields and reset value
// ----------------------------------------
`define BCG_CTRL_EN_BIT 0
`define BCG_CTRL_CLR_BIT 1
`define BCG_CTRL_RST 1'h1

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define BCG_ST_STATE_LSB 0
`define BCG_ST_CMD_BIT 2
`define BCG_ST_DLY_OK_BIT 3
`define BCG_ST_SEL_BIT 4
`define BCG_ST_GATE_BIT 5
`define BCG_ST_GRANT_BIT 6
`define BCG_ST_STRAP_BIT 7

// ----------------------------------------
// Command output positions
// ----------------------------------------
`define BCG_CMD_INTA 0
`define BCG_CMD_IORD 1
`define BCG_CMD_IOWR 2
`define BCG_CMD_MRD 3
`define BCG_CMD_MWR 4

// ----------------------------------------
// Timing counts in clock edges
// ----------------------------------------
`define BCG_GRANT_EDGES 2'h3
`define BCG_RD_DELAY 2'h1
`define BCG_WR_DELAY 2'h2
`define BCG_WR_DEN_DELAY 2'h1

// ----------------------------------------
// Synchroniser reset image of the pins
// ----------------------------------------
`define BCG_PIN_RST 8'h1B

`endif

// ===== rtl/bcg_sync.v
`timescale 1ns/1ps

module bcg_sync #(
   parameter W = 8,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Asynchronous pins in, synchronised levels out.
   input wire [W-1:0] d,
   output wire [W-1:0] q
);

   // ----------------------------------------
   // Two-stage synchroniser per bit
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_ff;
         reg sync_ff;
         // Only the second stage is visible; the first may be metastable.
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_ff <= RST_VAL[i];
               sync_ff <= RST_VAL[i];
            end else begin
               meta_ff <= d[i];
               sync_ff <= meta_ff;
            end
         end
         assign q[i] = sync_ff;
      end
   endgenerate

endmodule

// ===== testbench/bcg_gate_ctrl_asserts.sv
`timescale 1ns/1ps
// ------
// Port checks of the command gating block.
// ------
module bcg_chk (
   // Clock and reset.
   input wire CLK,
   input wire RST_B,
   // Pins driven by the far side.
   input wire CYCLE_STATUS_HI_B,
   input wire CYCLE_STATUS_LO_B,
   input wire SHARED_GATE_PIN,
   input wire COMMAND_DELAY_REQ,
   input wire READY_B,
   input wire BUS_TIMING_STRAP,
   // Outputs watched.
   input wire [4:0] CMD_B,
   input wire CMD_OE,
   input wire ADDR_LATCH_STROBE,
   input wire DATA_ENABLE_OUT,
   input wire DATA_DIRECTION_OUT
);
   logic [3:0] up_ff;
   wire up = &up_ff;
   // The strap is only trusted once the pin synchronisers have settled after reset.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B)
         up_ff <= 4'h0;
      else if (!up)
         up_ff <= up_ff + 4'h1;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_rest; CYCLE_STATUS_HI_B && CYCLE_STATUS_LO_B && !READY_B; endsequence
   sequence s_shut; up && !BUS_TIMING_STRAP && !SHARED_GATE_PIN; endsequence
   sequence s_drop; up && BUS_TIMING_STRAP && SHARED_GATE_PIN; endsequence
   sequence s_give; up && BUS_TIMING_STRAP && !SHARED_GATE_PIN; endsequence
   sequence s_hold; up && COMMAND_DELAY_REQ; endsequence
   property p_ale; ADDR_LATCH_STROBE |=> !ADDR_LATCH_STROBE; endproperty
   a_ale: assert property (p_ale) else $error("strobe longer than one clock");
   property p_shut; s_shut [*3] |-> CMD_B == 5'h1F && !DATA_ENABLE_OUT; endproperty
   a_shut: assert property (p_shut) else $error("gate low but outputs live");
   property p_drop; s_drop [*3] |-> !CMD_OE && !DATA_ENABLE_OUT; endproperty
   a_drop: assert property (p_drop) else $error("grant gone but drivers on");
   property p_rise; up && BUS_TIMING_STRAP && $rose(CMD_OE) |-> !$past(SHARED_GATE_PIN, 3);
   endproperty
   a_rise: assert property (p_rise) else $error("drivers on too early");
   property p_give; s_give [*8] |-> CMD_OE; endproperty
   a_give: assert property (p_give) else $error("drivers still off");
   property p_rest; s_rest [*8] |-> CMD_B == 5'h1F && !DATA_ENABLE_OUT && DATA_DIRECTION_OUT;
   endproperty
   a_rest: assert property (p_rest) else $error("outputs live after cycle end");
   property p_hold; s_hold [*6] |-> &CMD_B || !CMD_OE; endproperty
   a_hold: assert property (p_hold) else $error("command while delayed");
   property p_read;
      CMD_OE && !(&{CMD_B[3], CMD_B[1], CMD_B[0]}) |-> !DATA_DIRECTION_OUT && DATA_ENABLE_OUT;
   endproperty
   a_read: assert property (p_read) else $error("read without data path");
endmodule
bind bcg_gate_ctrl bcg_chk u_chk (.CLK, .RST_B, .CYCLE_STATUS_HI_B, .CYCLE_STATUS_LO_B,
   .SHARED_GATE_PIN, .COMMAND_DELAY_REQ, .READY_B, .BUS_TIMING_STRAP, .CMD_B, .CMD_OE,
   .ADDR_LATCH_STROBE, .DATA_ENABLE_OUT, .DATA_DIRECTION_OUT);

// ===== testbench/bcg_far.sv
`timescale 1ns/1ps
// ------
// Processor, decoder and arbiter side.
// ------
module bcg_far (
   // Clock and strap.
   input wire clk,
   input wire strap,
   // Status, select and control pins.
   output logic hi_b,
   output logic lo_b,
   output logic mem_io,
   output logic sel,
   output logic gate,
   output logic dly,
   output logic rdy_b,
   // Block outputs watched.
   input wire [4:0] cmd_b,
   input wire cmd_oe,
   input wire ale,
   input wire cascade_enable_out,
   input wire data_enable_out,
   input wire dtr
);
   // Status lines rest high, as their pull-ups would leave them.
   initial begin
      {mem_io, hi_b, lo_b} = 3'h3;
      sel = 1'b0;
      gate = 1'b1;
      dly = 1'b0;
      rdy_b = 1'b0;
   end
   // Puts the shared pin at its open level while idle.
   task automatic park;
      @(posedge clk);
      gate <= !strap;
   endtask
   // One bus cycle; gm 0 keeps the gate open, 1 shut, 2 opens it late.
   task automatic run(input int typ, input bit s, input bit d, input int gm,
         input int w, output logic [4:0] c, output logic [3:0] f);
      c = 5'h0;
      f = 4'h0;
      @(posedge clk);
      {mem_io, hi_b, lo_b} <= typ[2:0];
      sel <= s;
      dly <= d;
      rdy_b <= 1'b1;
      gate <= (gm == 0) ? !strap : strap;
      for (int k = 0; k < w + 14; k++) begin
         @(posedge clk);
         if (k == 0)
            {hi_b, lo_b} <= 2'h3;
         // Select drops once sampled, so the block must hold its own copy.
         if (k == 2)
            sel <= 1'b0;
         if (k == 1 && gm == 2)
            gate <= !strap;
         if (k == w + 1)
            rdy_b <= 1'b0;
         // Reopen well before the next cycle, since the grant needs three edges.
         if (k == w + 6) begin
            gate <= !strap;
            dly <= 1'b0;
         end
         #1;
         c = c | (~cmd_b & {5{cmd_oe}});
         f = f | {cascade_enable_out, ale, !dtr, data_enable_out};
      end
   endtask
endmodule

// ===== testbench/tb_bus_command_gating_control.sv
`timescale 1ns/1ps
// ------
// Self-checking bench: a cycle model set against the block.
// ------
module tb_bus_command_gating_control;
   logic clk, rst_b, strap, psel, penable, pwrite, pready, pslverr;
   logic hi_b, lo_b, mem_io, sel, gate, dly, rdy_b, cmd_oe, ale, cascade_enable_out, data_enable_out, dtr;
   logic [4:0] cmd_b;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rng;
   int miscompares, checks_done, nocmd;
   int types[6] = '{0, 1, 2, 4, 5, 6};
   bcg_gate_ctrl dut (
      .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CYCLE_STATUS_HI_B(hi_b), .CYCLE_STATUS_LO_B(lo_b), .MEM_IO(mem_io),
      .CYCLE_SELECT_LATCHED(sel), .SHARED_GATE_PIN(gate), .COMMAND_DELAY_REQ(dly),
      .READY_B(rdy_b), .BUS_TIMING_STRAP(strap), .CMD_B(cmd_b), .CMD_OE(cmd_oe),
      .ADDR_LATCH_STROBE(ale), .CASCADE_ENABLE_OUT(cascade_enable_out), .DATA_ENABLE_OUT(data_enable_out),
      .DATA_DIRECTION_OUT(dtr));
   bcg_far far (.clk, .strap, .hi_b, .lo_b, .mem_io, .sel, .gate, .dly, .rdy_b, .cmd_b,
      .cmd_oe, .ale, .cascade_enable_out, .data_enable_out, .dtr);
   // Clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Prints the counts and the verdict, then stops.
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Xorshift source, so every run sees the same stimulus.
   function automatic int rnd(input int m);
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return int'(rng[15:0]) % m;
   endfunction
   // One APB transfer; the wait for ready is bounded so a dead slave cannot hang us.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n == 64)
         miscompares++;
      rd = prdata;
      chk("slave error", {31'h0, pslverr}, {31'h0, a > 12'h00C});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Strap is set with reset and held, as the block captures it once.
   task automatic restart(input logic s);
      @(posedge clk);
      rst_b <= 1'b0;
      strap <= s;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      far.park;
      repeat (8) @(posedge clk);
   endtask
   // Runs one cycle and sets what was seen against the cycle model.
   task automatic cyc(input int typ, input bit s, input bit d, input int gm, input int w);
      logic [4:0] c, ec;
      logic [3:0] f, ef;
      bit wr, live;
      wr = typ[1];
      live = s && typ != 4 && gm != 1;
      far.run(typ, s, d, gm, w, c, f);
      ec = 5'h0;
      if (live && !d && (!strap || w >= 1 + wr))
         ec[typ > 4 ? typ - 2 : typ] = 1'b1;
      ef = {typ == 0, typ != 4, s && typ != 4 && !wr, live};
      // Early write enable timing is left open for unselected high-speed or short shared-mode cycles.
      if (wr && (strap ? w < 2 : !s))
         ef[0] = f[0];
      nocmd += (ec == 5'h0);
      chk("command", {27'h0, c}, {27'h0, ec});
      chk("control", {28'h0, f}, {28'h0, ef});
   endtask
   task automatic batch(input int n, input bit all);
      int typ, gm;
      for (int i = 0; i < n; i++) begin
         typ = types[i % 6];
         gm = all ? 0 : rnd(3);
         if (all && typ == 4)
            typ = 5;
         cyc(typ, all || rnd(4) != 0, rnd(4) == 0, gm, gm == 2 ? 6 : rnd(3) + strap);
      end
   endtask
   // Main sequence.
   initial begin
      {rst_b, strap, psel, penable, pwrite, paddr, pwdata} = '0;
      rng = 32'h3860F81E;
      restart(1'b0);
      apb(1'b0, 12'h000, 32'h0);
      chk("control word", rd, 32'h1);
      apb(1'b1, 12'h000, 32'h3);
      nocmd = 0;
      batch(6, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk("cycle count", rd, 32'h6);
      apb(1'b0, 12'h00C, 32'h0);
      chk("no-command count", rd, nocmd);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped word", rd, 32'h0);
      $display("test registers done");
      batch(30, 1'b0);
      $display("test fast timing done");
      restart(1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk("strap status", rd & 32'h80, 32'h80);
      batch(30, 1'b0);
      $display("test shared timing done");
      print_verdict;
   end
   // Watchdog sized well past the expected run of some 1200 clocks.
   initial begin
      repeat (9000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
endmodule
